// >>> dv/central_station.sv
`timescale 1ns/1ps
// Station that fetches and acknowledges records over the register bus.
module central_station
  import fault_rec_pkg::*;
(
  input wire logic pclk,
  input wire logic pready,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : central_station

// >>> dv/waveform_fault_recorder_properties.sv
`timescale 1ns/1ps
module waveform_fault_recorder_properties
  import fault_rec_pkg::*;
#(
  parameter int SAMPLE_CYCLES = SAMPLE_CYCLES_DOC
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic recording_start_flag,
  input wire logic records_deleted,
  input wire logic recording_running,
  input wire logic transfer_pending
);
  localparam int RUN_MAX = (int'(REC_LIMIT_SAMPLES) + 2) * SAMPLE_CYCLES;
  localparam int RUN_MIN = 39 * SAMPLE_CYCLES;
  logic en;
  int run_cnt;
  wire unmapped = paddr[1:0] == 2'h0 && (paddr == 8'h2C || paddr > 8'h44);
  wire cmd_wr = psel && pwrite && paddr == ADDR_CMD;
  wire ctrl_wr = psel && penable && pwrite && ce && paddr == ADDR_CTRL;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en <= 1'b0;
      run_cnt <= 0;
    end
    else
    begin
      en <= ctrl_wr ? pwdata[0] : en;
      run_cnt <= recording_running ? run_cnt + 1 : 0;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_ready_always: assert property (pready) else $error("pready low");
  a_unmapped_err: assert property (psel && penable && unmapped |-> pslverr) else $error("no slverr");
  a_err_access_only: assert property (pslverr |-> psel && penable && (pwrite || prdata == 32'h0)) else $error("bad slverr");
  a_flag_one_cycle: assert property (recording_start_flag |=> !recording_start_flag) else $error("long flag");
  a_flag_with_run: assert property (recording_start_flag |-> recording_running) else $error("flag idle");
  a_flag_from_idle: assert property (recording_start_flag |-> !$past(recording_running)) else $error("restart");
  a_flag_needs_en: assert property (!en |-> !recording_start_flag) else $error("start while off");
  a_delete_pulse: assert property (records_deleted |=> !records_deleted) else $error("long delete");
  a_run_max_len: assert property (run_cnt <= RUN_MAX) else $error("record too long");
  a_run_min_post: assert property ($fell(recording_running) && en |-> run_cnt >= RUN_MIN) else $error("short");
  a_pending_drop: assert property ($fell(transfer_pending) |-> $past(cmd_wr) || cmd_wr) else $error("lost");
  c_start: cover property (recording_start_flag);
  c_delete: cover property (records_deleted);
  c_ack: cover property ($fell(transfer_pending));
  c_err: cover property (pslverr);
endmodule : waveform_fault_recorder_properties

bind waveform_fault_recorder waveform_fault_recorder_properties #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) props_u (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .recording_start_flag(recording_start_flag), .records_deleted(records_deleted),
  .recording_running(recording_running), .transfer_pending(transfer_pending));

// >>> dv/waveform_fault_recorder_tb.sv
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) \
    begin \
      miscompares++; \
      $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end
module waveform_fault_recorder_tb;
  import fault_rec_pkg::*;
  localparam int SC = 4;
  localparam logic [7:0] RA [10] = '{ADDR_CTRL, ADDR_MAXLEN, ADDR_PRE, ADDR_POST, ADDR_BINTIME,
    ADDR_TRACKS, ADDR_CMD, ADDR_STATUS, 8'h2C, 8'h48};
  localparam logic [32:0] RV [10] = '{33'h0, 33'h0C8, 33'h019, 33'h00A, 33'h032,
    {1'b0, TRACK_RST}, 33'h0, 33'h0, 33'h100000000, 33'h100000000};
  localparam logic [7:0] CA [8] = '{ADDR_MAXLEN, ADDR_MAXLEN, ADDR_PRE, ADDR_PRE, ADDR_POST, ADDR_POST,
    ADDR_BINTIME, ADDR_BINTIME};
  localparam logic [9:0] CW [8] = '{10'h0, 10'h3FF, 10'h0, 10'h3FF, 10'h0, 10'h3FF, 10'h1, 10'h3FF};
  localparam logic [9:0] CE [8] = '{10'h01E, 10'h1F4, 10'h005, 10'h032, 10'h005, 10'h032, 10'h00A, 10'h1F4};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  currents_t currents = '0;
  logic pickup = 1'b0, trip = 1'b0, reclose_busy = 1'b0, capture_trigger = 1'b0, operator_trigger = 1'b0;
  logic [15:0] internal_signals = 16'h0;
  logic hold_inputs = 1'b0;
  logic recording_start_flag, records_deleted, recording_running, transfer_pending;
  int miscompares = 0;
  int comparisons = 0;
  int flags = 0;
  int deletes = 0;
  logic [32:0] exp_q [$];
  logic [32:0] exp_v;
  always #5 pclk = ~pclk;
  waveform_fault_recorder #(.SAMPLE_CYCLES(SC)) dut_u (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .currents(currents), .pickup(pickup), .trip(trip),
    .reclose_busy(reclose_busy), .capture_trigger(capture_trigger), .operator_trigger(operator_trigger),
    .internal_signals(internal_signals), .recording_start_flag(recording_start_flag),
    .records_deleted(records_deleted), .recording_running(recording_running),
    .transfer_pending(transfer_pending));
  central_station host_u (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata));
  always @(posedge pclk)
  begin
    if (!hold_inputs)
    begin
      currents <= currents_t'({$urandom, $urandom, $urandom});
      internal_signals <= 16'($urandom);
    end
    flags += int'(recording_start_flag);
    deletes += int'(records_deleted);
    if (psel && penable && pready && !pwrite)
    begin
      exp_v = exp_q.pop_front();
      `CHK({pslverr, prdata}, exp_v)
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host_u.xfer(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    host_u.xfer(1'b0, a, 32'h0);
  endtask : rd
  task automatic ticks(input int n);
    repeat (n * SC) @(posedge pclk);
  endtask : ticks
  task automatic wait_idle();
    ticks(2);
    while (recording_running !== 1'b0)
      @(posedge pclk);
  endtask : wait_idle
  task automatic rec(input logic [3:0] s, input logic t, input int len);
    wr(ADDR_REC_SEL, {28'h0, s});
    rd(ADDR_REC_INFO, {15'h0, t, 1'b1, 16'(len)});
  endtask : rec
  task automatic fault(input int n, input logic t);
    pickup <= 1'b1;
    trip <= t;
    ticks(n);
    pickup <= 1'b0;
    trip <= 1'b0;
    wait_idle();
  endtask : fault
  task automatic wrap_up();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up
  initial
  begin
    #400_000;
    miscompares++;
    wrap_up();
  end
  initial
  begin
    int n;
    void'($urandom(60980));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 10; i++)
      rd(RA[i], RV[i]);
    for (int i = 0; i < 8; i++)
    begin
      wr(CA[i], {22'h0, CW[i]});
      rd(CA[i], {23'h0, CE[i]});
    end
    $display("end of settings test");
    wr(ADDR_PRE, 32'h5);
    wr(ADDR_POST, 32'h5);
    wr(ADDR_BINTIME, 32'hA);
    fault(6, 1'b0);
    `CHK(flags, 0)
    wr(ADDR_CTRL, 32'h1);
    ticks(50);
    n = 4 + $urandom % 12;
    fault(n, 1'b0);
    rec(0, 1'b0, 81 + n);
    rd(ADDR_STATUS, {17'h0, 4'h1, 4'h1, 4'h1, 4'h0});
    wr(ADDR_CTRL, 32'h9);
    reclose_busy <= 1'b1;
    pickup <= 1'b1;
    ticks(4);
    pickup <= 1'b0;
    ticks(4);
    pickup <= 1'b1;
    ticks(4);
    pickup <= 1'b0;
    reclose_busy <= 1'b0;
    wait_idle();
    rec(1, 1'b0, 93);
    `CHK(flags, 2)
    $display("end of fault test");
    wr(ADDR_CTRL, 32'h3);
    fault(4, 1'b0);
    rd(ADDR_STATUS, {17'h0, 4'h2, 4'h2, 4'h2, 4'h0});
    for (int m = 3; m <= 5; m += 2)
    begin
      wr(ADDR_CTRL, 32'(m));
      fault(4, 1'b1);
      rec(4'(m / 2 + 1), 1'b1, 85);
    end
    $display("end of mode test");
    wr(ADDR_CTRL, 32'h1);
    for (int s = 0; s < 3; s++)
    begin
      capture_trigger <= s == 0;
      if (s == 1)
        wr(ADDR_CMD, 32'h1);
      operator_trigger <= s == 2;
      @(posedge pclk);
      operator_trigger <= 1'b0;
      ticks(2);
      capture_trigger <= 1'b0;
      wait_idle();
      rec(4'(4 + s), 1'b0, 161);
    end
    wr(ADDR_BINTIME, 32'h0);
    capture_trigger <= 1'b1;
    ticks(n);
    capture_trigger <= 1'b0;
    wait_idle();
    rec(7, 1'b0, 81 + n);
    wr(ADDR_MAXLEN, 32'h1E);
    capture_trigger <= 1'b1;
    ticks(300);
    capture_trigger <= 1'b0;
    wait_idle();
    rec(0, 1'b0, 321);
    rec(1, 1'b0, 93);
    `CHK(deletes, 1)
    $display("end of capture test");
    wr(ADDR_CTRL, 32'h21);
    repeat (16) wr(ADDR_CMD, 32'h2);
    `CHK(transfer_pending, 1'b0)
    fault(4, 1'b0);
    `CHK(transfer_pending, 1'b0)
    fault(4, 1'b1);
    `CHK(transfer_pending, 1'b1)
    wr(ADDR_CMD, 32'h4);
    ticks(1);
    `CHK(deletes, 4)
    $display("end of transfer test");
    hold_inputs <= 1'b1;
    wr(ADDR_CTRL, 32'h11);
    ticks(50);
    wr(ADDR_CMD, 32'h1);
    wait_idle();
    wr(ADDR_REC_SEL, 32'h3);
    wr(ADDR_RD_OFF, 32'h0);
    rd(ADDR_RD_BASE, {17'h0, currents.ia});
    rd(ADDR_RD_BASE + 8'h04, {17'h0, currents.ib});
    rd(ADDR_RD_BASE + 8'h08, {17'h0, currents.ic});
    rd(ADDR_RD_BASE + 8'h0C, {17'h0, currents.ignd2});
    rd(ADDR_RD_BASE + 8'h10, {17'h0, currents.i4});
    rd(ADDR_RD_BASE + 8'h14, {25'h0, internal_signals[7:0]});
    $display("end of sample test");
    wrap_up();
  end
endmodule : waveform_fault_recorder_tb

// >>> hdl/fault_rec_pkg.sv
package fault_rec_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int SAMPLE_PERIOD_US = 1250;
  localparam int SAMPLE_CYCLES_DOC = SAMPLE_PERIOD_US * 1000 / CLK_PERIOD_NS;
  localparam int SAMPLES_PER_CYCLE = 16;
  localparam int REC_LIMIT_MS = 5000;
  localparam int SET_UNIT_US = 10000;
  localparam logic [15:0] SAMPLES_PER_UNIT = 16'(SET_UNIT_US / SAMPLE_PERIOD_US);
  localparam logic [15:0] REC_LIMIT_SAMPLES = 16'(REC_LIMIT_MS * 1000 / SAMPLE_PERIOD_US);
  localparam int MIN_RECORDS = 8;
  localparam int MIN_TOTAL_MS = 20000;
  localparam int MIN_TOTAL_SAMPLES = MIN_TOTAL_MS * 1000 / SAMPLE_PERIOD_US;

  localparam logic [9:0] MAXLEN_MIN = 10'h01E;
  localparam logic [9:0] MAXLEN_MAX = 10'h1F4;
  localparam logic [9:0] MAXLEN_RST = 10'h0C8;
  localparam logic [9:0] WIN_MIN = 10'h005;
  localparam logic [9:0] WIN_MAX = 10'h032;
  localparam logic [9:0] PRE_RST = 10'h019;
  localparam logic [9:0] POST_RST = 10'h00A;
  localparam logic [9:0] BIN_MIN = 10'h00A;
  localparam logic [9:0] BIN_RST = 10'h032;
  localparam logic [9:0] BIN_INFINITE = 10'h000;
  localparam logic [31:0] TRACK_RST = 32'h76543210;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MAXLEN = 8'h04;
  localparam logic [7:0] ADDR_PRE = 8'h08;
  localparam logic [7:0] ADDR_POST = 8'h0C;
  localparam logic [7:0] ADDR_BINTIME = 8'h10;
  localparam logic [7:0] ADDR_TRACKS = 8'h14;
  localparam logic [7:0] ADDR_CMD = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1C;
  localparam logic [7:0] ADDR_REC_SEL = 8'h20;
  localparam logic [7:0] ADDR_REC_INFO = 8'h24;
  localparam logic [7:0] ADDR_RD_OFF = 8'h28;
  localparam logic [7:0] ADDR_RD_BASE = 8'h30;
  localparam int RD_WORDS = 6;

  localparam int CMD_TRIG = 0;
  localparam int CMD_ACK = 1;
  localparam int CMD_DELETE = 2;

  typedef enum logic [1:0] {
    MODE_SAVE_PICKUP = 2'h0,
    MODE_SAVE_TRIP = 2'h1,
    MODE_START_TRIP = 2'h2
  } trig_mode_t;

  typedef struct packed {
    logic [15:0] ia;
    logic [15:0] ib;
    logic [15:0] ic;
    logic [15:0] ignd;
    logic [15:0] ignd2;
    logic [15:0] i4;
  } currents_t;

  typedef struct packed {
    logic [15:0] ia;
    logic [15:0] ib;
    logic [15:0] ic;
    logic [15:0] ignd;
    logic [15:0] isens;
    logic [7:0] tracks;
  } sample_t;

  typedef struct packed {
    logic valid;
    logic tripped;
    logic [31:0] start;
    logic [15:0] length;
  } record_t;

endpackage : fault_rec_pkg

// >>> hdl/waveform_fault_recorder.sv
`timescale 1ns/1ps

// Function
// - Currents are sampled every 1.25 ms, sixteen per cycle, into a ring buffer.
// - No stored record exceeds five seconds.
// - Memory holds at least eight records and twenty seconds in total.
// - Each new fault is captured without acknowledging older records.
// - Triggers come from pickup, binary input, operator panel and serial interface.
// - Nothing is captured unless the recorder enable switch is set.
// - In normal mode time zero is the first protection pickup.
// - Trigger modes: save on pickup, save on trip, start on trip.
// - A fault event runs from first pickup until the last pickup drops.
// - Whole system fault scope keeps recording through reclose dead times; in start on trip mode only trip holds the record open, reclose_busy is ignored.
// - Record spans pre-trigger time before reference to post time after criterion.
// - Maximum record length is 0.30 to 5.00 s, default 2.00 s.
// - Pre-trigger time is 0.05 to 0.50 s, default 0.25 s.
// - Post-trigger time is 0.05 to 0.50 s, default 0.10 s.
// - Binary or PC trigger records the capture time, capped, plus both windows.
// - Infinite capture time follows the binary input, capped at maximum length.
// - Configurable binary tracks of internal signals are stored with each sample.
// - Each finished record is offered for polled transfer, all faults or trips.
// - Provide start flag, capture trigger input, deleted event, running status.
// - Alternative connection maps second ground current to the ground track; fourth current always feeds the sensitive track.
module waveform_fault_recorder
  import fault_rec_pkg::*;
#(
  parameter int NREC = 8,
  parameter int DEPTH = 16384,
  parameter int SAMPLE_CYCLES = SAMPLE_CYCLES_DOC
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire currents_t currents,
  input wire logic pickup,
  input wire logic trip,
  input wire logic reclose_busy,
  input wire logic capture_trigger,
  input wire logic operator_trigger,
  input wire logic [15:0] internal_signals,
  output logic recording_start_flag,
  output logic records_deleted,
  output logic recording_running,
  output logic transfer_pending
);

  localparam int AW = $clog2(DEPTH);
  localparam int SW = $bits(sample_t);
  localparam int RW = $clog2(NREC);

  initial
  begin
    if (NREC < MIN_RECORDS || (1 << RW) != NREC) $error("NREC must be a power of two of at least 8");
    if ((1 << AW) != DEPTH || DEPTH < MIN_TOTAL_SAMPLES) $error("DEPTH must be a power of two of 20 s");
    if (SAMPLE_CYCLES < 2) $error("SAMPLE_CYCLES too small");
  end

  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_ACTIVE = 3'b010,
    S_POST = 3'b100
  } state_t;

  function automatic logic [9:0] clamp(input logic [9:0] v, input logic [9:0] lo, input logic [9:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp

  function automatic logic [15:0] to_samples(input logic [9:0] s);
    to_samples = 16'(16'(s) * SAMPLES_PER_UNIT);
  endfunction : to_samples

  logic rec_enable;
  trig_mode_t trig_mode;
  logic scope_system;
  logic conn_alt;
  logic poll_trip_only;
  logic [9:0] maxlen_set;
  logic [9:0] pre_set;
  logic [9:0] post_set;
  logic [9:0] bin_set;
  logic [31:0] track_sel;
  logic [RW-1:0] rec_sel;
  logic [15:0] rd_off;
  logic serial_req;
  logic operator_req;
  logic [3:0] pending_cnt;

  state_t state;
  logic [31:0] tick_cnt;
  logic [31:0] wr_abs;
  sample_t mem [DEPTH];
  record_t rec [NREC];
  logic [RW-1:0] next_slot;
  logic [31:0] start_abs;
  logic [15:0] ref_cnt;
  logic [15:0] post_cnt;
  logic src_bin;
  logic seen_trip;
  logic pickup_q;
  logic trip_q;
  logic bin_q;

  wire setup = psel & ~penable;
  wire wr_en = psel & penable & pwrite;
  wire [7:0] rd_index = 8'(paddr - ADDR_RD_BASE) >> 2;
  wire rd_window = (paddr >= ADDR_RD_BASE) && (rd_index < 8'(RD_WORDS)) && (paddr[1:0] == 2'h0);
  wire known = (paddr == ADDR_CTRL) || (paddr == ADDR_MAXLEN) || (paddr == ADDR_PRE) || (paddr == ADDR_POST)
    || (paddr == ADDR_BINTIME) || (paddr == ADDR_TRACKS) || (paddr == ADDR_CMD) || (paddr == ADDR_STATUS)
    || (paddr == ADDR_REC_SEL) || (paddr == ADDR_REC_INFO) || (paddr == ADDR_RD_OFF) || rd_window;
  wire cmd_wr = wr_en && (paddr == ADDR_CMD);

  wire tick = ce && (tick_cnt == 32'(SAMPLE_CYCLES - 1));
  wire capture_on = rec_enable;

  sample_t cur_sample;
  logic [7:0] tracks;
  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_track
      assign tracks[g] = internal_signals[track_sel[4*g +: 4]];
    end
  endgenerate
  assign cur_sample.ia = currents.ia;
  assign cur_sample.ib = currents.ib;
  assign cur_sample.ic = currents.ic;
  assign cur_sample.ignd = conn_alt ? currents.ignd2 : currents.ignd;
  assign cur_sample.isens = currents.i4;
  assign cur_sample.tracks = tracks;

  wire [15:0] maxlen_smp = to_samples(maxlen_set);
  wire [15:0] pre_smp = to_samples(pre_set);
  wire [15:0] post_smp = to_samples(post_set);
  wire [15:0] bin_smp = to_samples(bin_set);
  wire bin_infinite = (bin_set == BIN_INFINITE);
  wire [15:0] bin_len = (bin_smp < maxlen_smp) ? bin_smp : maxlen_smp;

  wire criterion = (trig_mode == MODE_START_TRIP) ? trip : (pickup | (scope_system & reclose_busy));
  wire ref_fault = (trig_mode == MODE_START_TRIP) ? (trip & ~trip_q) : (pickup & ~pickup_q);
  wire ref_bin = (capture_trigger & ~bin_q) | serial_req | operator_req;
  wire [31:0] rec_len_now = wr_abs - start_abs;
  wire at_limit = rec_len_now >= 32'(REC_LIMIT_SAMPLES - 16'h0001);
  wire active_done = src_bin
    ? (bin_infinite ? (~capture_trigger || ref_cnt >= maxlen_smp) : (ref_cnt >= bin_len))
    : (~criterion || ref_cnt >= maxlen_smp);
  wire post_done = post_cnt >= post_smp;
  wire finish = tick && (((state == S_ACTIVE) && at_limit) || ((state == S_POST) && (post_done || at_limit)));
  wire keep = src_bin || (trig_mode != MODE_SAVE_TRIP) || seen_trip || trip;
  wire store = finish && keep;
  wire offer = store && (~poll_trip_only || seen_trip || trip);

  logic [NREC-1:0] rec_live;
  logic [3:0] valid_cnt;
  generate
    for (g = 0; g < NREC; g++)
    begin : g_live
      assign rec_live[g] = rec[g].valid && ((wr_abs - rec[g].start) <= 32'(DEPTH));
    end
  endgenerate
  always_comb
  begin
    valid_cnt = 4'h0;
    for (int i = 0; i < NREC; i++)
      valid_cnt = valid_cnt + 4'(rec_live[i]);
  end

  record_t sel_rec;
  sample_t rd_sample;
  logic [15:0] rd_word;
  assign sel_rec = rec[rec_sel];
  assign rd_sample = mem[AW'(sel_rec.start + 32'(rd_off))];
  always_comb
  begin
    unique case (rd_index)
      8'h00: rd_word = rd_sample.ia;
      8'h01: rd_word = rd_sample.ib;
      8'h02: rd_word = rd_sample.ic;
      8'h03: rd_word = rd_sample.ignd;
      8'h04: rd_word = rd_sample.isens;
      default: rd_word = {8'h00, rd_sample.tracks};
    endcase
  end

  logic [31:0] next_prdata;
  always_comb
  begin
    next_prdata = 32'h00000000;
    if (rd_window)
      next_prdata = {16'h0000, rd_word};
    else
      unique case (paddr)
        ADDR_CTRL: next_prdata = {26'h0, poll_trip_only, conn_alt, scope_system, trig_mode, rec_enable};
        ADDR_MAXLEN: next_prdata = {22'h0, maxlen_set};
        ADDR_PRE: next_prdata = {22'h0, pre_set};
        ADDR_POST: next_prdata = {22'h0, post_set};
        ADDR_BINTIME: next_prdata = {22'h0, bin_set};
        ADDR_TRACKS: next_prdata = track_sel;
        ADDR_STATUS: next_prdata = {16'h0, 4'(next_slot), pending_cnt, valid_cnt, 3'h0, recording_running};
        ADDR_REC_SEL: next_prdata = {29'h0, 3'(rec_sel)};
        ADDR_REC_INFO: next_prdata = {14'h0, sel_rec.tripped, rec_live[rec_sel], sel_rec.length};
        ADDR_RD_OFF: next_prdata = {16'h0, rd_off};
        default: next_prdata = 32'h00000000;
      endcase
  end

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~known;
  assign recording_running = (state != S_IDLE);
  assign transfer_pending = (pending_cnt != 4'h0);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (ce && setup && !pwrite)
      prdata <= next_prdata;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rec_enable <= 1'b0;
      trig_mode <= MODE_SAVE_PICKUP;
      scope_system <= 1'b0;
      conn_alt <= 1'b0;
      poll_trip_only <= 1'b0;
      maxlen_set <= MAXLEN_RST;
      pre_set <= PRE_RST;
      post_set <= POST_RST;
      bin_set <= BIN_RST;
      track_sel <= TRACK_RST;
      rec_sel <= '0;
      rd_off <= 16'h0000;
    end
    else if (ce && wr_en)
    begin
      unique case (paddr)
        ADDR_CTRL:
        begin
          rec_enable <= pwdata[0];
          trig_mode <= (pwdata[2:1] == 2'h3) ? MODE_SAVE_PICKUP : trig_mode_t'(pwdata[2:1]);
          scope_system <= pwdata[3];
          conn_alt <= pwdata[4];
          poll_trip_only <= pwdata[5];
        end
        ADDR_MAXLEN: maxlen_set <= clamp(pwdata[9:0], MAXLEN_MIN, MAXLEN_MAX);
        ADDR_PRE: pre_set <= clamp(pwdata[9:0], WIN_MIN, WIN_MAX);
        ADDR_POST: post_set <= clamp(pwdata[9:0], WIN_MIN, WIN_MAX);
        ADDR_BINTIME: bin_set <= (pwdata[9:0] == BIN_INFINITE) ? BIN_INFINITE
          : clamp(pwdata[9:0], BIN_MIN, MAXLEN_MAX);
        ADDR_TRACKS: track_sel <= pwdata;
        ADDR_REC_SEL: rec_sel <= pwdata[RW-1:0];
        ADDR_RD_OFF: rd_off <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      serial_req <= 1'b0;
      operator_req <= 1'b0;
    end
    else if (ce)
    begin
      serial_req <= (cmd_wr && pwdata[CMD_TRIG] && capture_on) || (serial_req && !(tick && state == S_IDLE));
      operator_req <= (operator_trigger && capture_on) || (operator_req && !(tick && state == S_IDLE));
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pending_cnt <= 4'h0;
    else if (ce)
      pending_cnt <= pending_cnt + 4'(offer && pending_cnt != 4'hF) - 4'(cmd_wr && pwdata[CMD_ACK] && pending_cnt != 4'h0);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_cnt <= 32'h00000000;
      wr_abs <= 32'h00000000;
      pickup_q <= 1'b0;
      trip_q <= 1'b0;
      bin_q <= 1'b0;
    end
    else if (ce)
    begin
      tick_cnt <= tick ? 32'h00000000 : tick_cnt + 32'h00000001;
      if (tick)
      begin
        pickup_q <= pickup;
        trip_q <= trip;
        bin_q <= capture_trigger;
        if (capture_on)
          wr_abs <= wr_abs + 32'h00000001;
      end
    end
  end

  always_ff @(posedge pclk)
  begin
    if (ce && tick && capture_on)
      mem[AW'(wr_abs)] <= cur_sample;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= S_IDLE;
      start_abs <= 32'h00000000;
      ref_cnt <= 16'h0000;
      post_cnt <= 16'h0000;
      src_bin <= 1'b0;
      seen_trip <= 1'b0;
    end
    else if (ce && tick)
    begin
      unique case (state)
        S_IDLE:
          if (capture_on && (ref_fault || ref_bin))
          begin
            state <= S_ACTIVE;
            start_abs <= wr_abs - 32'(pre_smp);
            ref_cnt <= 16'h0001;
            src_bin <= ~ref_fault;
            seen_trip <= trip;
          end
        S_ACTIVE:
        begin
          ref_cnt <= ref_cnt + 16'h0001;
          seen_trip <= seen_trip | trip;
          if (at_limit || !capture_on)
            state <= S_IDLE;
          else if (active_done)
          begin
            state <= S_POST;
            post_cnt <= 16'h0001;
          end
        end
        S_POST:
        begin
          post_cnt <= post_cnt + 16'h0001;
          if (post_done || at_limit || !capture_on)
            state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      next_slot <= '0;
      recording_start_flag <= 1'b0;
      records_deleted <= 1'b0;
      for (int i = 0; i < NREC; i++)
        rec[i] <= '0;
    end
    else if (ce)
    begin
      recording_start_flag <= tick && state == S_IDLE && capture_on && (ref_fault || ref_bin);
      records_deleted <= (store && rec_live[next_slot]) || (cmd_wr && pwdata[CMD_DELETE]);
      if (cmd_wr && pwdata[CMD_DELETE])
        for (int i = 0; i < NREC; i++)
          rec[i].valid <= 1'b0;
      if (store)
      begin
        rec[next_slot].valid <= 1'b1;
        rec[next_slot].tripped <= seen_trip | trip;
        rec[next_slot].start <= start_abs;
        rec[next_slot].length <= 16'(rec_len_now + 32'h00000001);
        next_slot <= next_slot + 1'b1;
      end
    end
  end

endmodule : waveform_fault_recorder
